//--- shared/adcwd_pkg.sv
/*
  adcwd_pkg: register offsets, field positions, reset values, timing
  constants and bus carriers for the converter scan and limit control.
  assumes an APB slave with 32-bit data and one word per register.
*/
package adcwd_pkg;
  // printed offsets are not multiples of four: they are register indices
  localparam logic [7:0] IDX_CH6_RESULT = 8'hf6;
  localparam logic [7:0] IDX_CH7_RESULT = 8'hf7;
  localparam logic [7:0] IDX_CH6_LOW = 8'hf8;
  localparam logic [7:0] IDX_CH7_LOW = 8'hf9;
  localparam logic [7:0] IDX_CH6_HIGH = 8'hfa;
  localparam logic [7:0] IDX_CH7_HIGH = 8'hfb;
  localparam logic [7:0] IDX_FLAGS = 8'hfc;
  localparam logic [7:0] IDX_CTRL = 8'hfd;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'hfe;
  localparam logic [7:0] IDX_IRQ_VEC = 8'hff;
  localparam int ADDR_W = 10;

  // limit compare flag bits
  localparam int FL_CH7_HIGH = 7;
  localparam int FL_CH6_HIGH = 6;
  localparam int FL_CH7_LOW = 5;
  localparam int FL_CH6_LOW = 4;
  localparam logic [7:0] FLAGS_LOW_ONES = 8'h0f;
  localparam logic [7:0] FLAGS_RESET = 8'h0f;

  // converter control bits
  localparam int CT_SCAN_HI = 7;
  localparam int CT_SCAN_LO = 5;
  localparam int CT_PIN_TRIG = 4;
  localparam int CT_TMR_TRIG = 3;
  localparam int CT_BIAS = 2;
  localparam int CT_REPEAT = 1;
  localparam int CT_RUN = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // irq control bits
  localparam int IC_DONE = 7;
  localparam int IC_ALARM = 6;
  localparam int IC_DONE_EN = 5;
  localparam int IC_ALARM_EN = 4;
  localparam int IC_PRIO_HI = 2;
  localparam int IC_PRIO_LO = 0;
  localparam logic [7:0] IRQC_RESET = 8'h0f;

  // irq vector bits
  localparam int IV_WORD = 1;
  localparam logic [7:0] IVEC_RESET = 8'h02;
  localparam logic [7:0] IVEC_BASE_MASK = 8'hfc;

  localparam logic [2:0] LAST_CHANNEL = 3'h7;

  // per-channel conversion time and its cycle count at 200 MHz
  localparam int CONV_TIME_NS = 11000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } adcwd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } adcwd_apb_rsp_t;

  typedef struct packed {
    logic req;
    logic [2:0] prio;
    logic wordSel;
  } adcwd_irq_t;
endpackage

//--- core/adcwd_ctrl.sv
/*
  adcwd_ctrl: scan sequencer, channel 6/7 limit guard and interrupt
  control of an eight-channel converter, with an APB register slave.
  assumes the analog front end takes a channel number and a start pulse
  while bias is on, and returns an 8-bit result with a done pulse; all
  inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module adcwd_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire adcwd_pkg::adcwd_apb_req_t apbReq,
  output adcwd_pkg::adcwd_apb_rsp_t apbRsp,
  input wire logic externalTriggerPin,
  input wire logic timerEvent,
  input wire logic convDone,
  input wire logic [7:0] convResult,
  output logic convStart,
  output logic [2:0] convChannel,
  output logic analogBiasOn,
  output adcwd_pkg::adcwd_irq_t irqOut
);
  import adcwd_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} adcwd_state_t;

  function automatic logic [7:0] regIdx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic [3:0] checkLimits(input logic [7:0] res,
      input logic [7:0] lo, input logic [7:0] hi);
    // {high, low} pair; window is lo <= res < hi
    return {2'b00, res >= hi, res < lo};
  endfunction

  adcwd_state_t state_ff, nxt_state;
  logic [7:0] ch6Result_ff, ch7Result_ff, ch6Low_ff, ch7Low_ff;
  logic [7:0] ch6High_ff, ch7High_ff;
  logic [3:0] limitFlags_ff, nxt_limitFlags;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] irqCtrl_ff, nxt_irqCtrl;
  logic [7:0] irqVec_ff, nxt_irqVec;
  logic [2:0] chan_ff, nxt_chan;
  logic pinPrev_ff, convStart_ff, bias_ff;
  logic [31:0] rdata_ff;
  logic ready_ff, err_ff;
  adcwd_irq_t irq_ff, nxt_irq;

  wire logic access = apbReq.psel && apbReq.penable && !ready_ff;
  wire logic wrEn = access && apbReq.pwrite;
  wire logic [7:0] idx = regIdx(apbReq.paddr);
  wire logic [7:0] wd = apbReq.pwdata[7:0];
  wire logic mapped = idx >= IDX_CH6_RESULT;
  wire logic wrCtrl = wrEn && idx == IDX_CTRL;
  wire logic wrIrqC = wrEn && idx == IDX_IRQ_CTRL;
  wire logic wrFlags = wrEn && idx == IDX_FLAGS;
  wire logic wrCh6Res = wrEn && idx == IDX_CH6_RESULT;
  wire logic wrCh7Res = wrEn && idx == IDX_CH7_RESULT;
  wire logic wrCh6Low = wrEn && idx == IDX_CH6_LOW;
  wire logic wrCh7Low = wrEn && idx == IDX_CH7_LOW;
  wire logic wrCh6High = wrEn && idx == IDX_CH6_HIGH;
  wire logic wrCh7High = wrEn && idx == IDX_CH7_HIGH;
  wire logic wrIrqVec = wrEn && idx == IDX_IRQ_VEC;

  // falling edge of the pin, the low pulse marks a trigger
  wire logic pinEdge = pinPrev_ff && !externalTriggerPin;
  wire logic trigRaw = (ctrl_ff[CT_PIN_TRIG] && pinEdge)
      || (ctrl_ff[CT_TMR_TRIG] && timerEvent);
  // triggers while a group runs are ignored
  wire logic trigger = trigRaw && !ctrl_ff[CT_RUN] && !wrCtrl;
  wire logic biasOn = ctrl_ff[CT_BIAS];
  wire logic [2:0] firstChan = ctrl_ff[CT_SCAN_HI:CT_SCAN_LO];
  wire logic repeatMode = ctrl_ff[CT_REPEAT];
  wire logic chanDone = state_ff == S_WAIT && convDone && !wrCtrl;
  wire logic groupEnd = chanDone && chan_ff == LAST_CHANNEL;
  wire logic [3:0] cmp6 = checkLimits(convResult, ch6Low_ff, ch6High_ff);
  wire logic [3:0] cmp7 = checkLimits(convResult, ch7Low_ff, ch7High_ff);
  wire logic hit6 = chanDone && chan_ff == 3'h6;
  wire logic hit7 = chanDone && chan_ff == LAST_CHANNEL;
  wire logic [3:0] cmpSet = {hit7 & cmp7[1], hit6 & cmp6[1],
      hit7 & cmp7[0], hit6 & cmp6[0]};
  wire logic alarmEvt = |cmpSet;
  wire logic irqFlagClr = wrIrqC && ((irqCtrl_ff[IC_DONE] && !wd[IC_DONE])
      || (irqCtrl_ff[IC_ALARM] && !wd[IC_ALARM]));
  wire logic doneReq = irqCtrl_ff[IC_DONE] && irqCtrl_ff[IC_DONE_EN];
  wire logic alarmReq = irqCtrl_ff[IC_ALARM] && irqCtrl_ff[IC_ALARM_EN];

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    unique case (state_ff)
      S_IDLE: begin
        nxt_chan = firstChan;
        if (ctrl_ff[CT_RUN] && biasOn) begin
          nxt_state = S_START;
        end
      end
      S_START: begin
        nxt_state = S_WAIT;
      end
      S_WAIT: begin
        if (chanDone) begin
          if (chan_ff != LAST_CHANNEL) begin
            nxt_chan = chan_ff + 3'h1;
            nxt_state = S_START;
          end else if (repeatMode && ctrl_ff[CT_RUN]) begin
            nxt_chan = firstChan;
            nxt_state = S_START;
          end else begin
            nxt_state = S_IDLE;
          end
        end
      end
    endcase
    // control write, run cleared or bias off abort the group
    if (wrCtrl || !ctrl_ff[CT_RUN] || !biasOn) begin
      nxt_state = S_IDLE;
      nxt_chan = wrCtrl ? wd[CT_SCAN_HI:CT_SCAN_LO] : firstChan;
    end
  end

  // control register
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrCtrl) begin
      nxt_ctrl = wd;
    end else if (trigger) begin
      nxt_ctrl[CT_RUN] = 1'b1;
    end else if (groupEnd && !repeatMode) begin
      nxt_ctrl[CT_RUN] = 1'b0;
    end
  end

  // limit flags: hardware set wins over software write
  always_comb begin
    nxt_limitFlags = limitFlags_ff;
    if (wrFlags) begin
      nxt_limitFlags = wd[7:4];
    end
    if (irqFlagClr) begin
      nxt_limitFlags = 4'h0;
    end
    nxt_limitFlags = nxt_limitFlags | cmpSet;
  end

  // irq control: a software write may set flags, raising a request
  always_comb begin
    nxt_irqCtrl = irqCtrl_ff;
    if (wrIrqC) begin
      nxt_irqCtrl = wd;
    end
    if (groupEnd) begin
      nxt_irqCtrl[IC_DONE] = 1'b1;
    end
    if (alarmEvt) begin
      nxt_irqCtrl[IC_ALARM] = 1'b1;
    end
  end

  // vector and request; alarm has priority, done waits
  always_comb begin
    nxt_irqVec = irqVec_ff;
    if (wrIrqVec) begin
      nxt_irqVec = (wd & IVEC_BASE_MASK) | (irqVec_ff & ~IVEC_BASE_MASK);
    end
    if (alarmReq) begin
      nxt_irqVec[IV_WORD] = 1'b0;
    end else if (doneReq) begin
      nxt_irqVec[IV_WORD] = 1'b1;
    end
    nxt_irq.req = doneReq || alarmReq;
    nxt_irq.prio = irqCtrl_ff[IC_PRIO_HI:IC_PRIO_LO];
    nxt_irq.wordSel = nxt_irqVec[IV_WORD];
  end

  // start comes from the next state so it rises with the channel it names
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      chan_ff <= 3'h0;
      convStart_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
      convStart_ff <= nxt_state == S_START;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
      bias_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      bias_ff <= nxt_ctrl[CT_BIAS];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      limitFlags_ff <= FLAGS_RESET[7:4];
    end else begin
      limitFlags_ff <= nxt_limitFlags;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqCtrl_ff <= IRQC_RESET;
    end else begin
      irqCtrl_ff <= nxt_irqCtrl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqVec_ff <= IVEC_RESET;
      irq_ff <= '0;
    end else begin
      irqVec_ff <= nxt_irqVec;
      irq_ff <= nxt_irq;
    end
  end

  // pin history resets to the idle high level, so no false edge follows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinPrev_ff <= 1'b1;
    end else begin
      pinPrev_ff <= externalTriggerPin;
    end
  end

  // result and limit registers: data only, no reset needed
  always_ff @(posedge ref_clk) begin
    if (hit6) begin
      ch6Result_ff <= convResult;
    end else if (wrCh6Res) begin
      ch6Result_ff <= wd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (hit7) begin
      ch7Result_ff <= convResult;
    end else if (wrCh7Res) begin
      ch7Result_ff <= wd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrCh6Low) begin
      ch6Low_ff <= wd;
    end
    if (wrCh7Low) begin
      ch7Low_ff <= wd;
    end
    if (wrCh6High) begin
      ch6High_ff <= wd;
    end
    if (wrCh7High) begin
      ch7High_ff <= wd;
    end
  end

  // apb: one wait state, answer in the cycle after the access phase opens
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    unique case (idx)
      IDX_CH6_RESULT: rdByte = ch6Result_ff;
      IDX_CH7_RESULT: rdByte = ch7Result_ff;
      IDX_CH6_LOW: rdByte = ch6Low_ff;
      IDX_CH7_LOW: rdByte = ch7Low_ff;
      IDX_CH6_HIGH: rdByte = ch6High_ff;
      IDX_CH7_HIGH: rdByte = ch7High_ff;
      IDX_FLAGS: rdByte = {limitFlags_ff, FLAGS_LOW_ONES[3:0]};
      IDX_CTRL: rdByte = ctrl_ff;
      IDX_IRQ_CTRL: rdByte = irqCtrl_ff;
      IDX_IRQ_VEC: rdByte = irqVec_ff & ~8'h01;
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= access;
    end
  end

  // an unmapped index answers with an error; writes there are dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= access && !mapped;
    end
  end

  // read data is zero outside the answer cycle so stale bytes never leak
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= access ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end

  assign apbRsp.pready = ready_ff;
  assign apbRsp.pslverr = err_ff;
  assign apbRsp.prdata = rdata_ff;
  assign convStart = convStart_ff;
  assign convChannel = chan_ff;
  assign analogBiasOn = bias_ff;
  assign irqOut = irq_ff;
endmodule
`default_nettype wire

//--- tb/adcwd_ctrl_asserts.sv
/* adcwd_ctrl_asserts: port-level checks of adcwd_ctrl, bound into it.
   assumes one clock and a synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module adcwd_ctrl_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire adcwd_pkg::adcwd_apb_req_t apbReq,
  input wire adcwd_pkg::adcwd_apb_rsp_t apbRsp,
  input wire logic convDone,
  input wire logic convStart,
  input wire logic [2:0] convChannel,
  input wire logic analogBiasOn
);
  import adcwd_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic take;
  wire logic ctrlStop;
  wire logic [7:0] idx;
  assign idx = apbReq.paddr[9:2];
  assign take = apbReq.psel && apbReq.penable && !apbRsp.pready;
  // run and both triggers off: nothing may start again
  assign ctrlStop = take && apbReq.pwrite && idx == IDX_CTRL &&
    (apbReq.pwdata[4:0] & 5'h19) == 5'h00;
  a_ready_wait: assert property (take |=> apbRsp.pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready too long");
  a_err_unmapped: assert property (apbRsp.pready |->
    apbRsp.pslverr == (idx < IDX_CH6_RESULT)) else $error("bad pslverr");
  a_flags_ones: assert property (apbRsp.pready && !apbReq.pwrite &&
    idx == IDX_FLAGS |-> apbRsp.prdata[3:0] == 4'hf)
    else $error("flag low bits");
  a_bias_gate: assert property (convStart |-> analogBiasOn)
    else $error("start with bias off");
  a_start_pulse: assert property (convStart |=> !convStart)
    else $error("start too long");
  // bus quiet at the done and the cycle before: no write aborted the scan
  a_next_chan: assert property (!apbReq.psel ##1
    (convDone && convChannel != 3'h7 && !apbReq.psel)
    |=> convStart && convChannel == $past(convChannel) + 3'h1)
    else $error("scan step");
  a_write_abort: assert property (ctrlStop |=> ##1 (!convStart)[*6])
    else $error("start after stop");
endmodule
bind adcwd_ctrl adcwd_ctrl_asserts adcwd_ctrl_asserts_inst (
  .ref_clk(ref_clk),
  .rst(rst),
  .apbReq(apbReq),
  .apbRsp(apbRsp),
  .convDone(convDone),
  .convStart(convStart),
  .convChannel(convChannel),
  .analogBiasOn(analogBiasOn)
);
`default_nettype wire

//--- tb/adcwd_front_end.sv
/* adcwd_front_end: behavioural analog front end, done lat+1 cycles after it samples a start.
   assumes one start per conversion; bias off drops the work in hand. */
`timescale 1ns/1ps
`default_nettype none
module adcwd_front_end (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic convStart,
  input wire logic [2:0] convChannel,
  input wire logic analogBiasOn,
  input wire logic [3:0] lat,
  input wire logic [7:0] lvl6,
  input wire logic [7:0] lvl7,
  output var logic convDone,
  output var logic [7:0] convResult
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  always_ff @(posedge ref_clk) begin
    convDone <= 1'h0;
    // result lines toggle outside the done pulse so stale data never matches
    convResult <= ~convResult;
    cnt_ff <= cnt_ff - 4'h1;
    if (rst) begin
      busy_ff <= 1'h0;
      convResult <= 8'h5a;
    end else if (convStart) begin
      busy_ff <= 1'h1;
      cnt_ff <= lat;
    end else if (!analogBiasOn) begin
      busy_ff <= 1'h0;
    end else if (busy_ff && cnt_ff == 4'h0) begin
      busy_ff <= 1'h0;
      convDone <= 1'h1;
      convResult <= convChannel == 3'h6 ? lvl6 :
        convChannel == 3'h7 ? lvl7 : 8'h11;
    end
  end
endmodule
`default_nettype wire

//--- tb/adcwd_ctrl_tb.sv
/* adcwd_ctrl_tb: self-checking bench for the scan and limit control.
   assumes the front end model and an APB master written here. */
`timescale 1ns/1ps
`default_nettype none
module adcwd_ctrl_tb;
  import adcwd_pkg::*;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  adcwd_apb_req_t req = '0;
  adcwd_apb_rsp_t rsp;
  adcwd_irq_t irq;
  logic pin = 1'h1;
  logic tmr = 1'h0;
  logic done, start, bias, rerr;
  logic [2:0] chan;
  logic [7:0] res;
  logic [3:0] lat = 4'h2;
  logic [31:0] rdat;
  logic [2:0] seen[$];
  int numErrors = 0;
  int nChecks = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (start === 1'h1) seen.push_back(chan);
  adcwd_ctrl adcwd_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
    .apbReq(req), .apbRsp(rsp), .externalTriggerPin(pin),
    .timerEvent(tmr), .convDone(done), .convResult(res),
    .convStart(start), .convChannel(chan), .analogBiasOn(bias),
    .irqOut(irq));
  adcwd_front_end adcwd_front_end_inst (.ref_clk(ref_clk), .rst(rst),
    .convStart(start), .convChannel(chan), .analogBiasOn(bias),
    .lat(lat), .lvl6(8'h80), .lvl7(8'h3f), .convDone(done),
    .convResult(res));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    req.psel <= 1'h1;
    req.pwrite <= w;
    req.paddr <= {i, 2'h0};
    req.pwdata <= {24'h0, d};
    @(posedge ref_clk);
    req.penable <= 1'h1;
    do @(posedge ref_clk); while (rsp.pready !== 1'h1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'h1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    apb(1'h0, i, 8'h0);
    chk(rdat[7:0], exp);
  endtask
  task automatic chkIrq(input logic [7:0] exp);
    repeat (2) @(posedge ref_clk);
    chk({3'h0, irq}, exp);
  endtask
  task automatic waitIdle();
    do apb(1'h0, IDX_CTRL, 8'h0); while (rdat[CT_RUN] !== 1'h0);
  endtask
  task automatic t_reset();
    rd(IDX_FLAGS, FLAGS_RESET);
    rd(IDX_CTRL, CTRL_RESET);
    rd(IDX_IRQ_CTRL, IRQC_RESET);
    rd(IDX_IRQ_VEC, IVEC_RESET);
    apb(1'h0, 8'h10, 8'h0);
    chk({7'h0, rerr}, 8'h01);
  endtask
  task automatic t_single();
    wr(IDX_CH6_LOW, 8'h40);
    wr(IDX_CH6_HIGH, 8'h80);
    wr(IDX_CH7_LOW, 8'h40);
    wr(IDX_CH7_HIGH, 8'h80);
    wr(IDX_IRQ_VEC, 8'ha8);
    wr(IDX_IRQ_CTRL, 8'h33);
    seen.delete();
    wr(IDX_CTRL, 8'hc5);
    waitIdle();
    chk(rdat[7:0], 8'hc4);
    chk(8'(seen.size()), 8'h02);
    chk({5'h0, seen[0]}, 8'h06);
    chk({5'h0, seen[1]}, 8'h07);
    rd(IDX_CH6_RESULT, 8'h80);
    rd(IDX_CH7_RESULT, 8'h3f);
    rd(IDX_FLAGS, 8'h6f);
    rd(IDX_IRQ_CTRL, 8'hf3);
    chkIrq(8'h16);
    rd(IDX_IRQ_VEC, 8'ha8);
    wr(IDX_IRQ_CTRL, 8'hb3);
    rd(IDX_FLAGS, FLAGS_LOW_ONES);
    rd(IDX_IRQ_VEC, 8'haa);
    wr(IDX_IRQ_CTRL, 8'h93);
    chkIrq(8'h07);
    wr(IDX_IRQ_CTRL, 8'h53);
    chkIrq(8'h16);
  endtask
  task automatic t_trig();
    lat <= 4'h6;
    wr(IDX_CTRL, 8'hf6);
    seen.delete();
    repeat (20) @(posedge ref_clk);
    chk(8'(seen.size()), 8'h00);
    pin <= 1'h0;
    repeat (3) @(posedge ref_clk);
    pin <= 1'h1;
    while (seen.size() < 3) @(posedge ref_clk);
    chk({5'h0, seen[2]}, 8'h07);
    rd(IDX_CTRL, 8'hf7);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_IRQ_CTRL, 8'hd3);
    chkIrq(8'h16);
    chk({7'h0, bias}, 8'h00);
    wr(IDX_CTRL, 8'hcc);
    seen.delete();
    tmr <= 1'h1;
    @(posedge ref_clk);
    tmr <= 1'h0;
    // bus stays quiet while channel 6 hands over to channel 7
    repeat (20) @(posedge ref_clk);
    waitIdle();
    pin <= 1'h0;
    repeat (30) @(posedge ref_clk);
    chk(8'(seen.size()), 8'h02);
  endtask
  task automatic conclude();
    if (numErrors == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset();
    t_single();
    t_trig();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    conclude();
  end
endmodule
`default_nettype wire
